// file: hdl/status_pkg.sv
// Constants for the bus event status and revision registers
package status_pkg;
	localparam logic [7:0] STATUS_OFFSET = 8'h06;
	localparam logic [7:0] REVISION_OFFSET = 8'h08;
	localparam logic [7:0] CAP_PTR_OFFSET = 8'h34;
	localparam logic [15:0] STATUS_RESET = 16'h0400;
	localparam int INT_PEND_BIT = 3;
	localparam int CAP_LIST_BIT = 4;
	localparam int FAST_BUS_BIT = 5;
	localparam int DEVSEL_LO_BIT = 9;
	localparam int DEVSEL_HI_BIT = 10;
	localparam int DPAR_REP_BIT = 8;
	localparam int TABORT_SIG_BIT = 11;
	localparam int TABORT_REC_BIT = 12;
	localparam int MABORT_BIT = 13;
	localparam int SERR_SIG_BIT = 14;
	localparam int PAR_DET_BIT = 15;
	localparam logic [1:0] DEVSEL_SLOW = 2'h2;
	localparam int CMD_PERR_ENA_BIT = 6;
	localparam int CMD_SERR_ENA_BIT = 8;
	localparam int CMD_INT_DIS_BIT = 10;
	localparam int EVENT_COUNT = 6;
	localparam logic [7:0] REVISION_DEFAULT = 8'h01;
endpackage : status_pkg

// file: hdl/event_if.sv
// Set and clear strobes between the status bank and its sticky flag cells
`timescale 1ns/1ps
interface event_if;
	logic [status_pkg::EVENT_COUNT-1:0] set_pulse;
	logic [status_pkg::EVENT_COUNT-1:0] clear_pulse;
	logic [status_pkg::EVENT_COUNT-1:0] flag;
	modport bank (output set_pulse, output clear_pulse, input flag);
	modport cells (input set_pulse, input clear_pulse, output flag);
endinterface : event_if

// file: hdl/sticky_flags.sv
// Sticky write-one-to-clear flags, set has priority over clear
`timescale 1ns/1ps
module sticky_flags (
	input wire logic core_clk,
	input wire logic rst_b,
	event_if.cells ev
);
	logic [status_pkg::EVENT_COUNT-1:0] flag_ff;
	logic [status_pkg::EVENT_COUNT-1:0] nxt_flag;

	genvar i;
	generate
		for (i = 0; i < status_pkg::EVENT_COUNT; i++) begin : g_flag
			always_comb begin
				if (ev.set_pulse[i]) begin // R19
					nxt_flag[i] = 1'b1;
				end else if (ev.clear_pulse[i]) begin // R1
					nxt_flag[i] = 1'b0;
				end else begin
					nxt_flag[i] = flag_ff[i];
				end
			end

			property p_set_wins;
				@(posedge core_clk) disable iff (!rst_b)
				(ev.set_pulse[i] && ev.clear_pulse[i]) |=> flag_ff[i];
			endproperty
			a_set_wins: assert property (p_set_wins) else $error("set lost to clear"); // R19
		end
	endgenerate

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			flag_ff <= '0;
		end else begin
			flag_ff <= nxt_flag;
		end
	end

	assign ev.flag = flag_ff;
endmodule : sticky_flags

// file: hdl/bus_event_status.sv
// Configuration status and revision registers of the bus function
//
// Function
// R1 - Status reads normal, write one clears
// R2 - Status resets to 0x0400
// R3 - Bit 3 shows interrupt line when enabled
// R4 - Bit 4 build-time capabilities list enable
// R5 - Bit 5 build-time fast bus capability
// R6 - Bit 8 set on reported data parity
// R7 - Bits 10:9 fixed to slow decode
// R8 - Bit 11 set on local-requested target abort
// R9 - Bit 12 set on received target abort
// R10 - Bit 13 set on master abort
// R11 - Bit 14 set on system error signalled
// R12 - Bit 15 set on any parity error
// R13 - Seven status bits mirrored to local bus
// R14 - Eight-bit fixed revision identifier register
// R15 - Interrupt disable waits for pending service
// R16 - Data parity reported only when enabled
// R17 - System error needs both enables set
// R18 - Reserved bits read zero, writes ignored
// R19 - Set beats clear in the same cycle
`timescale 1ns/1ps
module bus_event_status #(
	parameter logic CAP_LIST_ENABLE = 1'b0,
	parameter logic FAST_BUS_CAPABLE = 1'b0,
	parameter logic [7:0] REVISION_VALUE = status_pkg::REVISION_DEFAULT
) (
	input wire logic core_clk,
	input wire logic rst_b,
	input wire logic cfg_wr,
	input wire logic cfg_rd,
	input wire logic [7:0] cfg_addr,
	input wire logic [15:0] cfg_wdata,
	output logic [15:0] cfg_rdata,
	input wire logic [15:0] command_value,
	input wire logic irq_request,
	output logic irq_line_out,
	input wire logic data_par_err_det,
	input wire logic addr_par_err_det,
	input wire logic local_abort_request_n,
	input wire logic target_abort_issued,
	input wire logic target_abort_seen,
	input wire logic master_abort_done,
	output logic data_par_err_out,
	output logic sys_err_out,
	output logic cap_ptr_enable,
	output logic [6:0] local_status
);
	event_if ev ();

	sticky_flags u_flags (
		.core_clk(core_clk),
		.rst_b(rst_b),
		.ev(ev)
	);

	logic perr_ena;
	logic serr_ena;
	logic int_dis;
	logic status_wr;
	logic irq_ff;
	logic nxt_irq;
	logic dpar_ff;
	logic nxt_dpar;
	logic serr_ff;
	logic nxt_serr;
	logic [15:0] rdata_ff;
	logic [15:0] nxt_rdata;
	logic [15:0] status_value;

	assign perr_ena = command_value[status_pkg::CMD_PERR_ENA_BIT];
	assign serr_ena = command_value[status_pkg::CMD_SERR_ENA_BIT];
	assign int_dis = command_value[status_pkg::CMD_INT_DIS_BIT];
	assign status_wr = cfg_wr && (cfg_addr == status_pkg::STATUS_OFFSET);

	// Interrupt line: a pending line is kept until serviced even if disabled
	always_comb begin
		if (irq_ff) begin
			nxt_irq = irq_request; // R15
		end else begin
			nxt_irq = irq_request && !int_dis; // R15
		end
	end

	// Parity and system error pins, each one cycle per detection
	always_comb begin
		nxt_dpar = data_par_err_det && perr_ena; // R16
		nxt_serr = addr_par_err_det && serr_ena && perr_ena; // R17
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			irq_ff <= 1'b0;
			dpar_ff <= 1'b0;
			serr_ff <= 1'b0;
		end else begin
			irq_ff <= nxt_irq;
			dpar_ff <= nxt_dpar;
			serr_ff <= nxt_serr;
		end
	end

	assign irq_line_out = irq_ff;
	assign data_par_err_out = dpar_ff;
	assign sys_err_out = serr_ff;
	assign cap_ptr_enable = CAP_LIST_ENABLE; // R4

	// Event order matches the local status bus bits 0 to 5
	always_comb begin
		ev.set_pulse[0] = dpar_ff; // R6
		ev.set_pulse[1] = target_abort_issued && !local_abort_request_n; // R8
		ev.set_pulse[2] = target_abort_seen; // R9
		ev.set_pulse[3] = master_abort_done; // R10
		ev.set_pulse[4] = serr_ff; // R11
		ev.set_pulse[5] = data_par_err_det || addr_par_err_det; // R12
	end

	always_comb begin
		ev.clear_pulse[0] = status_wr && cfg_wdata[status_pkg::DPAR_REP_BIT]; // R1
		ev.clear_pulse[1] = status_wr && cfg_wdata[status_pkg::TABORT_SIG_BIT]; // R1
		ev.clear_pulse[2] = status_wr && cfg_wdata[status_pkg::TABORT_REC_BIT]; // R1
		ev.clear_pulse[3] = status_wr && cfg_wdata[status_pkg::MABORT_BIT]; // R1
		ev.clear_pulse[4] = status_wr && cfg_wdata[status_pkg::SERR_SIG_BIT]; // R1
		ev.clear_pulse[5] = status_wr && cfg_wdata[status_pkg::PAR_DET_BIT]; // R1
	end

	// Assembled status word; reserved bits stay zero
	always_comb begin
		status_value = 16'h0000; // R18
		status_value[status_pkg::INT_PEND_BIT] = irq_ff && !int_dis; // R3
		status_value[status_pkg::CAP_LIST_BIT] = CAP_LIST_ENABLE; // R4
		status_value[status_pkg::FAST_BUS_BIT] = FAST_BUS_CAPABLE; // R5
		status_value[status_pkg::DPAR_REP_BIT] = ev.flag[0];
		status_value[status_pkg::DEVSEL_HI_BIT:status_pkg::DEVSEL_LO_BIT] =
			status_pkg::DEVSEL_SLOW; // R7
		status_value[status_pkg::TABORT_SIG_BIT] = ev.flag[1];
		status_value[status_pkg::TABORT_REC_BIT] = ev.flag[2];
		status_value[status_pkg::MABORT_BIT] = ev.flag[3];
		status_value[status_pkg::SERR_SIG_BIT] = ev.flag[4];
		status_value[status_pkg::PAR_DET_BIT] = ev.flag[5];
	end

	always_comb begin
		if (!cfg_rd) begin
			nxt_rdata = rdata_ff;
		end else if (cfg_addr == status_pkg::STATUS_OFFSET) begin
			nxt_rdata = status_value; // R1
		end else if (cfg_addr == status_pkg::REVISION_OFFSET) begin
			nxt_rdata = {8'h00, REVISION_VALUE}; // R14
		end else begin
			nxt_rdata = 16'h0000;
		end
	end

	always_ff @(posedge core_clk or negedge rst_b) begin
		if (!rst_b) begin
			rdata_ff <= status_pkg::STATUS_RESET; // R2
		end else begin
			rdata_ff <= nxt_rdata;
		end
	end

	assign cfg_rdata = rdata_ff;
	assign local_status = {status_value[status_pkg::INT_PEND_BIT], ev.flag}; // R13

	property p_dpar_gated;
		@(posedge core_clk) disable iff (!rst_b)
		(data_par_err_det && !perr_ena) |=> !data_par_err_out;
	endproperty
	a_dpar_gated: assert property (p_dpar_gated) else $error("parity reported while off"); // R16

	// Output pulse first, then the sticky flag one cycle later
	sequence s_serr_reported;
		sys_err_out ##1 local_status[4];
	endsequence

	property p_serr_needs_both;
		@(posedge core_clk) disable iff (!rst_b)
		addr_par_err_det && serr_ena && perr_ena |=> s_serr_reported;
	endproperty
	a_serr_needs_both: assert property (p_serr_needs_both) else $error("serr not flagged"); // R11

	property p_par_detect;
		@(posedge core_clk) disable iff (!rst_b)
		(data_par_err_det || addr_par_err_det) |=> local_status[5];
	endproperty
	a_par_detect: assert property (p_par_detect) else $error("parity not detected"); // R12

	sequence s_dpar_reported;
		data_par_err_out ##1 local_status[0];
	endsequence

	property p_dpar_flag;
		@(posedge core_clk) disable iff (!rst_b)
		(data_par_err_det && perr_ena) |=> s_dpar_reported;
	endproperty
	a_dpar_flag: assert property (p_dpar_flag) else $error("data parity flag not set"); // R6

	property p_tabort_sig;
		@(posedge core_clk) disable iff (!rst_b)
		(target_abort_issued && !local_abort_request_n) |=> local_status[1];
	endproperty
	a_tabort_sig: assert property (p_tabort_sig) else $error("target abort flag not set"); // R8

	property p_abort_rec;
		@(posedge core_clk) disable iff (!rst_b)
		target_abort_seen |=> local_status[2];
	endproperty
	a_abort_rec: assert property (p_abort_rec) else $error("abort received flag missing"); // R9

	property p_mabort;
		@(posedge core_clk) disable iff (!rst_b)
		master_abort_done |=> local_status[3];
	endproperty
	a_mabort: assert property (p_mabort) else $error("master abort flag missing"); // R10

	property p_clear;
		@(posedge core_clk) disable iff (!rst_b)
		(status_wr && cfg_wdata[status_pkg::MABORT_BIT] && !master_abort_done) |=>
			!local_status[3];
	endproperty
	a_clear: assert property (p_clear) else $error("write one did not clear"); // R1

	property p_fixed_bits;
		@(posedge core_clk) disable iff (!rst_b)
		cfg_rd && cfg_addr == status_pkg::STATUS_OFFSET |=>
			cfg_rdata[10:9] == 2'h2 && cfg_rdata[7:6] == 2'h0 && cfg_rdata[2:0] == 3'h0;
	endproperty
	a_fixed_bits: assert property (p_fixed_bits) else $error("fixed status bits wrong"); // R7

	property p_int_dis_hold;
		@(posedge core_clk) disable iff (!rst_b)
		(!irq_line_out && int_dis) |=> !irq_line_out;
	endproperty
	a_int_dis_hold: assert property (p_int_dis_hold) else $error("line raised while disabled"); // R15

	property p_irq_raise;
		@(posedge core_clk) disable iff (!rst_b)
		(irq_request && !int_dis) |=> irq_line_out;
	endproperty
	a_irq_raise: assert property (p_irq_raise) else $error("enabled request not on line"); // R15

	property p_irq_kept;
		@(posedge core_clk) disable iff (!rst_b)
		(irq_line_out && irq_request) |=> irq_line_out;
	endproperty
	a_irq_kept: assert property (p_irq_kept) else $error("pending line dropped early"); // R15

	property p_irq_released;
		@(posedge core_clk) disable iff (!rst_b)
		!irq_request |=> !irq_line_out;
	endproperty
	a_irq_released: assert property (p_irq_released) else $error("line kept after service"); // R15

	property p_int_pend_read;
		@(posedge core_clk) disable iff (!rst_b)
		(cfg_rd && cfg_addr == status_pkg::STATUS_OFFSET && irq_line_out && !int_dis) |=>
			cfg_rdata[status_pkg::INT_PEND_BIT];
	endproperty
	a_int_pend_read: assert property (p_int_pend_read) else $error("pending bit not read"); // R3

	property p_rdata_hold;
		@(posedge core_clk) disable iff (!rst_b)
		!cfg_rd |=> $stable(cfg_rdata);
	endproperty
	a_rdata_hold: assert property (p_rdata_hold) else $error("read data moved without read"); // R1

	property p_write_zero_keeps;
		@(posedge core_clk) disable iff (!rst_b)
		(status_wr && !cfg_wdata[status_pkg::MABORT_BIT] && local_status[3]) |=> local_status[3];
	endproperty
	a_write_zero_keeps: assert property (p_write_zero_keeps) else $error("zero write cleared"); // R1

	property p_par_clear;
		@(posedge core_clk) disable iff (!rst_b)
		(status_wr && cfg_wdata[status_pkg::PAR_DET_BIT] && !data_par_err_det &&
			!addr_par_err_det) |=> !local_status[5];
	endproperty
	a_par_clear: assert property (p_par_clear) else $error("parity flag not cleared"); // R1

	property p_serr_gated;
		@(posedge core_clk) disable iff (!rst_b)
		(addr_par_err_det && !(serr_ena && perr_ena)) |=> !sys_err_out;
	endproperty
	a_serr_gated: assert property (p_serr_gated) else $error("system error while disabled"); // R17

	property p_tabort_not_local;
		@(posedge core_clk) disable iff (!rst_b)
		(target_abort_issued && local_abort_request_n && !local_status[1]) |=> !local_status[1];
	endproperty
	a_tabort_not_local: assert property (p_tabort_not_local) else $error("abort flag set"); // R8

	property p_revision_read;
		@(posedge core_clk) disable iff (!rst_b)
		cfg_rd && cfg_addr == status_pkg::REVISION_OFFSET |=>
			cfg_rdata == {8'h00, REVISION_VALUE};
	endproperty
	a_revision_read: assert property (p_revision_read) else $error("revision value wrong"); // R14

	property p_build_bits;
		@(posedge core_clk) disable iff (!rst_b)
		cfg_rd && cfg_addr == status_pkg::STATUS_OFFSET |=>
			cfg_rdata[status_pkg::CAP_LIST_BIT] == CAP_LIST_ENABLE &&
			cfg_rdata[status_pkg::FAST_BUS_BIT] == FAST_BUS_CAPABLE;
	endproperty
	a_build_bits: assert property (p_build_bits) else $error("build bits wrong"); // R5
endmodule : bus_event_status

// file: dv/host_model.sv
// Host side model issuing configuration reads and writes
`timescale 1ns/1ps
module host_model (
	input wire logic core_clk,
	output logic cfg_wr,
	output logic cfg_rd,
	output logic [7:0] cfg_addr,
	output logic [15:0] cfg_wdata
);
	initial begin
		cfg_wr = 1'b0;
		cfg_rd = 1'b0;
		cfg_addr = 8'h00;
		cfg_wdata = 16'h0000;
	end
	task automatic xfer(input logic w, input logic [7:0] a, input logic [15:0] d);
		@(posedge core_clk);
		cfg_wr <= w;
		cfg_rd <= ~w;
		cfg_addr <= a;
		cfg_wdata <= d;
		@(posedge core_clk);
		cfg_wr <= 1'b0;
		cfg_rd <= 1'b0;
		// Released lines never keep the last value
		cfg_addr <= ~a;
		cfg_wdata <= ~d;
	endtask : xfer
endmodule : host_model

// file: dv/tb.sv
// Self-checking bench for the bus event status registers
`timescale 1ns/1ps
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin n_errors++; \
	$display("[FAIL] %0t got %h exp %h", $time, a, b); end end
module tb;
	logic core_clk, rst_b, cfg_wr, cfg_rd, irq_request, dpe, ape, abort_n;
	logic irq_line_out, dpo, seo, cap_en;
	logic [7:0] cfg_addr;
	logic [15:0] cfg_wdata, cfg_rdata, command_value;
	logic [2:0] ev;
	logic [6:0] local_status;
	int n_errors = 0, n_tests = 0, cycles = 0, n_dpo = 0, n_seo = 0;
	initial begin
		core_clk = 1'b0;
		forever #5 core_clk = ~core_clk;
	end
	always @(posedge core_clk) begin
		cycles <= cycles + 1;
		n_dpo <= n_dpo + dpo;
		n_seo <= n_seo + seo;
		if (cycles == 3000) begin
			$display("[FAIL] %0t timeout", $time);
			n_errors++;
			report_and_stop();
		end
	end
	host_model i_host_model (.core_clk(core_clk), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
		.cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata));
	bus_event_status #(.CAP_LIST_ENABLE(1'b1), .FAST_BUS_CAPABLE(1'b1),
		.REVISION_VALUE(8'h5A)) i_bus_event_status (.core_clk(core_clk), .rst_b(rst_b),
		.cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata),
		.cfg_rdata(cfg_rdata), .command_value(command_value), .irq_request(irq_request),
		.irq_line_out(irq_line_out), .data_par_err_det(dpe), .addr_par_err_det(ape),
		.local_abort_request_n(abort_n), .target_abort_issued(ev[0]),
		.target_abort_seen(ev[1]), .master_abort_done(ev[2]), .data_par_err_out(dpo),
		.sys_err_out(seo), .cap_ptr_enable(cap_en), .local_status(local_status));
	task automatic rd(input logic [7:0] a, input logic [15:0] e);
		i_host_model.xfer(1'b0, a, 16'h0000);
		@(negedge core_clk);
		`CHK(cfg_rdata, e)
	endtask : rd
	task automatic wr(input logic [7:0] a, input logic [15:0] d);
		i_host_model.xfer(1'b1, a, d);
	endtask : wr
	// Bits: address parity, data parity, master abort, abort seen, abort issued
	task automatic pulse(input logic [4:0] p);
		@(posedge core_clk);
		{ape, dpe, ev} <= p;
		@(posedge core_clk);
		{ape, dpe, ev} <= 5'h00;
		repeat (3) @(posedge core_clk);
	endtask : pulse
	task automatic t_regs;
		`CHK(cfg_rdata, 16'h0400)
		`CHK(local_status, 7'h00)
		`CHK(cap_en, 1'b1)
		rd(8'h06, 16'h0430);
		wr(8'h06, 16'hFFFF);
		rd(8'h06, 16'h0430);
		rd(8'h08, 16'h005A);
		rd(8'h40, 16'h0000);
		$display("test regs done");
	endtask : t_regs
	task automatic t_abort;
		@(posedge core_clk);
		abort_n <= 1'b0;
		for (int i = 0; i < 3; i++) begin
			pulse(5'h01 << i);
			`CHK(local_status[i+1], 1'b1)
			rd(8'h06, 16'h0430 | (16'h0800 << i));
			wr(8'h06, ~(16'h0800 << i));
			rd(8'h06, 16'h0430 | (16'h0800 << i));
			wr(8'h06, 16'h0800 << i);
			rd(8'h06, 16'h0430);
		end
		@(posedge core_clk);
		abort_n <= 1'b1;
		pulse(5'h01);
		rd(8'h06, 16'h0430);
		$display("test abort done");
	endtask : t_abort
	task automatic t_parity;
		logic p, s;
		for (int m = 0; m < 4; m++) begin
			p = m[0];
			s = m[0] & m[1];
			@(posedge core_clk);
			command_value <= {7'h00, m[1], 1'b0, m[0], 6'h00};
			pulse(5'h18);
			`CHK(local_status[5:0], {1'b1, s, 3'h0, p})
			rd(8'h06, {1'b1, s, 4'h1, 1'b0, p, 8'h30});
			wr(8'h06, 16'hC100);
		end
		`CHK(n_dpo, 2)
		`CHK(n_seo, 1)
		command_value <= 16'h0000;
		// Each parity source alone must still mark the detected bit
		for (int k = 3; k < 5; k++) begin
			pulse(5'h01 << k);
			`CHK(local_status[5:0], 6'h20)
			wr(8'h06, 16'h8000);
		end
		$display("test parity done");
	endtask : t_parity
	task automatic t_irq;
		@(posedge core_clk);
		irq_request <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(irq_line_out, 1'b1)
		rd(8'h06, 16'h0438);
		`CHK(local_status[6], 1'b1)
		@(posedge core_clk);
		command_value <= 16'h0400;
		rd(8'h06, 16'h0430);
		`CHK(irq_line_out, 1'b1)
		@(posedge core_clk);
		irq_request <= 1'b0;
		repeat (3) @(posedge core_clk);
		irq_request <= 1'b1;
		repeat (3) @(posedge core_clk);
		`CHK(irq_line_out, 1'b0)
		irq_request <= 1'b0;
		command_value <= 16'h0000;
		$display("test irq done");
	endtask : t_irq
	task automatic t_race;
		pulse(5'h02);
		fork
			wr(8'h06, 16'h1000);
			pulse(5'h02);
		join
		rd(8'h06, 16'h1430);
		wr(8'h06, 16'h1000);
		rd(8'h06, 16'h0430);
		$display("test race done");
	endtask : t_race
	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", n_tests, n_errors);
		if (n_errors == 0 && n_tests > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask : report_and_stop
	initial begin
		rst_b = 1'b0;
		{irq_request, dpe, ape, ev} = 6'h00;
		abort_n = 1'b1;
		command_value = 16'h0000;
		repeat (5) @(posedge core_clk);
		rst_b <= 1'b1;
		@(negedge core_clk);
		t_regs();
		t_abort();
		t_parity();
		t_irq();
		t_race();
		report_and_stop();
	end
endmodule : tb
